// ==== tag_consts.vh ====
// Constants for the touch acquisition gating controller
// Assumes inclusion by bare name from design files
`ifndef TAG_CONSTS_VH
`define TAG_CONSTS_VH

// Register indices and byte addresses (index times four)
`define TAG_IDX_CTRL_ONE 5'h01
`define TAG_IDX_CTRL_TWO 5'h02
`define TAG_ADDR_CTRL_ONE 12'h004
`define TAG_ADDR_CTRL_TWO 12'h008
`define TAG_ADDR_STATUS 12'h00C
`define TAG_ADDR_RESULT_BASE 12'h000
// Result read addresses
`define TAG_RES_PRESSURE_FIRST 5'h1A
`define TAG_RES_PRESSURE_SECOND 5'h12
// Field positions
`define TAG_BIT_SINGLE_DIFF 11
`define TAG_BIT_START 10
`define TAG_BIT_HOLD_POL 3
`define TAG_CHAN_LSB 0
// Channel codes
`define TAG_CH_X 4'hC
`define TAG_CH_Y 4'hD
`define TAG_CH_PRESSURE_FIRST 4'hA
`define TAG_CH_PRESSURE_SECOND 4'h2
// Reset values
`define TAG_CTRL_ONE_RST 12'h000
`define TAG_CTRL_TWO_RST 12'h000
// Timing in ns and derived cycles at 100 MHz
`define TAG_CLK_NS 10
`define TAG_ACQ_NS 2000
`define TAG_CONV_NS 6000
`define TAG_DELAY_NS 1000
`define TAG_ACQ_CYC ((`TAG_ACQ_NS + `TAG_CLK_NS - 1) / `TAG_CLK_NS)
`define TAG_CONV_CYC ((`TAG_CONV_NS + `TAG_CLK_NS - 1) / `TAG_CLK_NS)
`define TAG_DELAY_CYC ((`TAG_DELAY_NS + `TAG_CLK_NS - 1) / `TAG_CLK_NS)

`endif

// ==== tag_hold_sync.v ====
// Two-stage synchroniser with polarity decode for the hold input
// Assumes clock and active-low reset from the top
`timescale 1ns/1ps
`default_nettype none
module tag_hold_sync
(
   input wire clock,
   input wire rstN,
   input wire holdIn,
   input wire holdPolarity,
   output reg holdActive
);
   reg meta_q;
   reg sync_q;

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         holdActive <= 1'b0;
      end
      else
      begin
         meta_q <= holdIn; // RULE16
         sync_q <= meta_q; // RULE16
         holdActive <= holdPolarity ? sync_q : ~sync_q; // RULE12
      end
   end
endmodule // tag_hold_sync
`default_nettype wire

// ==== tag_plate_model.sv ====
// Plate and LCD model: screen level held while the converter samples
// Assumes plate switch outputs and a noise request from the bench
`timescale 1ns/1ps
`default_nettype none
module tag_plate_model
(
   input wire logic clock,
   input wire logic acqEnable,
   input wire logic [3:0] drv,
   input wire logic [1:0] senseSel,
   input wire logic lcdNoisy,
   input wire logic polHigh,
   output logic holdLine,
   output logic [11:0] convData
);
   logic [5:0] held_q;
   always @(posedge clock)
      if (acqEnable)
         held_q <= {drv, senseSel};
   assign convData = {6'h2B, held_q};
   // Quiet LCD leaves the hold line at its inactive level
   assign holdLine = polHigh ? lcdNoisy : ~lcdNoisy;
endmodule // tag_plate_model
`default_nettype wire

// ==== tag_touch_ctrl.v ====
// Touch acquisition gating controller: APB registers, plate switch
// control and acquisition gating by the hold input.
// Assumes a converter that samples while acqEnable is high and converts
// while convActive is high; convData is stored at the edge where convActive falls.
// What this block does
// RULE1: Bit 11 of control one chooses ratiometric (0, default) or single-ended (1).
// RULE2: Single-ended X drives the X plate and senses Y+ against the chip reference.
// RULE3: Ratiometric Y puts the reference across the Y plate and senses X+.
// RULE4: Ratiometric mode keeps excitation on through the whole conversion.
// RULE5: Single-ended mode drops excitation once the input is sampled.
// RULE6: Pressure drives Y+ to X-, first senses Y-, second senses X+.
// RULE7: Channel 1010b is the first pressure reading, stored at result 11010b.
// RULE8: Channel 0010b is the second pressure reading, stored at result 10010b.
// RULE9: No acquisition starts while the hold input is active.
// RULE10: A hold during acquisition aborts it and restarts once hold ends.
// RULE11: Hold polarity is bit 3 of control two at address 0x02.
// RULE12: Polarity 1 means active high, 0 active low, resetting to 0.
// RULE13: The system ties the hold input inactive to disable holding.
// RULE14: Hold is ignored during conversion and the first-conversion delay.
// RULE15: Holding applies to every converter channel.
// RULE16: The hold input passes three flip-flops (two synchroniser stages, then the polarity decode) before gating acquisition.
`timescale 1ns/1ps
`default_nettype none
`include "tag_consts.vh"
module tag_touch_ctrl
#(
   parameter ACQ_CYC = `TAG_ACQ_CYC,
   parameter CONV_CYC = `TAG_CONV_CYC,
   parameter DELAY_CYC = `TAG_DELAY_CYC
)
(
   input wire clock,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire acquisition_hold_in,
   input wire [11:0] convData,
   output reg acqEnable,
   output reg convActive,
   output reg [3:0] convChannel,
   output reg xPosDrive,
   output reg xNegDrive,
   output reg yPosDrive,
   output reg yNegDrive,
   output reg [1:0] senseSel,
   output reg refRatiometric,
   output reg [1:0] refPlate
);
   // States, one-hot
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_DELAY = 5'b00010;
   localparam [4:0] ST_ACQ = 5'b00100;
   localparam [4:0] ST_CONV = 5'b01000;
   localparam [4:0] ST_STORE = 5'b10000;
   // Sense selections
   localparam [1:0] SN_XP = 2'h0;
   localparam [1:0] SN_YP = 2'h1;
   localparam [1:0] SN_YN = 2'h2;
   // Reference plate: 0 none, 1 X plate, 2 Y plate
   localparam [1:0] RP_NONE = 2'h0;
   localparam [1:0] RP_X = 2'h1;
   localparam [1:0] RP_Y = 2'h2;
   // Register indices not carried in the header
   localparam [4:0] IDX_STATUS = 5'h03;
   localparam [4:0] RES_X = 5'h1C;
   localparam [4:0] RES_Y = 5'h1D;

   reg rstMeta_q;
   reg rstN_q;
   reg [11:0] ctrlOne_q;
   reg [11:0] ctrlTwo_q;
   reg [4:0] state_q;
   reg [15:0] count_q;
   reg [3:0] chan_q;
   reg [11:0] resPressFirst_q;
   reg [11:0] resPressSecond_q;
   reg [11:0] resX_q;
   reg [11:0] resY_q;
   reg [7:0] abortCount_q;
   wire holdActive;
   wire singleEnded;
   wire apbAccess;
   wire apbWrite;
   wire [4:0] resIdx;

   assign singleEnded = ctrlOne_q[`TAG_BIT_SINGLE_DIFF]; // RULE1
   assign apbAccess = psel & penable & ~pready;
   // Writes land only at the edge that completes the access
   assign apbWrite = psel & penable & pready & pwrite;
   assign resIdx = paddr[6:2];

   // Map a channel code to its result address
   function [4:0] resAddrOf;
      input [3:0] ch;
      begin
         resAddrOf = {1'b1, ch};
      end
   endfunction

   // Internal reset: asserts at once, releases after two edges
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_q <= 1'b0;
         rstN_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstN_q <= rstMeta_q;
      end
   end

   // Hold input crosses two flops, then the polarity decode
   tag_hold_sync uHoldSync
   (
      .clock(clock),
      .rstN(rstN_q),
      .holdIn(acquisition_hold_in),
      .holdPolarity(ctrlTwo_q[`TAG_BIT_HOLD_POL]), // RULE11
      .holdActive(holdActive)
   );

   // APB slave: one wait state, answer in the access cycle after
   always @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         ctrlOne_q <= `TAG_CTRL_ONE_RST;
         ctrlTwo_q <= `TAG_CTRL_TWO_RST; // RULE12
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apbAccess;
         pslverr <= 1'b0;
         if (apbWrite)
         begin
            case (paddr)
               `TAG_ADDR_CTRL_ONE: ctrlOne_q <= pwdata[11:0];
               `TAG_ADDR_CTRL_TWO: ctrlTwo_q <= pwdata[11:0]; // RULE11
               default: ctrlTwo_q <= ctrlTwo_q;
            endcase
         end
         if (apbAccess)
         begin
            prdata <= 32'h00000000;
            if (pwrite)
            begin
               // Error flag must stand with pready, so decode it early
               if (paddr != `TAG_ADDR_CTRL_ONE &&
                  paddr != `TAG_ADDR_CTRL_TWO)
                  pslverr <= 1'b1;
            end
            else if (paddr[11:7] != 5'h00 || paddr[1:0] != 2'h0)
               pslverr <= 1'b1;
            else
            begin
               case (resIdx)
                  `TAG_IDX_CTRL_ONE: prdata <= {20'h00000, ctrlOne_q};
                  `TAG_IDX_CTRL_TWO: prdata <= {20'h00000, ctrlTwo_q};
                  IDX_STATUS:
                     prdata <= {19'h0, abortCount_q, holdActive,
                        state_q[3:0]};
                  `TAG_RES_PRESSURE_FIRST:
                     prdata <= {20'h00000, resPressFirst_q}; // RULE7
                  `TAG_RES_PRESSURE_SECOND:
                     prdata <= {20'h00000, resPressSecond_q}; // RULE8
                  RES_X: prdata <= {20'h00000, resX_q};
                  RES_Y: prdata <= {20'h00000, resY_q};
                  default: pslverr <= 1'b1;
               endcase
            end
         end
      end
   end

   // Conversion sequencer
   always @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         state_q <= ST_IDLE;
         count_q <= 16'h0000;
         chan_q <= 4'h0;
         resPressFirst_q <= 12'h000;
         resPressSecond_q <= 12'h000;
         resX_q <= 12'h000;
         resY_q <= 12'h000;
         abortCount_q <= 8'h00;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (apbWrite && paddr == `TAG_ADDR_CTRL_ONE &&
                  pwdata[`TAG_BIT_START])
               begin
                  chan_q <= pwdata[3:0];
                  count_q <= 16'h0000;
                  state_q <= ST_DELAY;
               end
            end
            ST_DELAY:
            begin
               // Hold input not looked at here
               if (count_q >= DELAY_CYC[15:0] - 16'h0001) // RULE14
               begin
                  count_q <= 16'h0000;
                  state_q <= ST_ACQ;
               end
               else
                  count_q <= count_q + 16'h0001;
            end
            ST_ACQ:
            begin
               // Same gating on every channel code
               if (holdActive) // RULE9 RULE15
               begin
                  // Partial sample is thrown away on a hold
                  if (count_q != 16'h0000) // RULE10
                     abortCount_q <= abortCount_q + 8'h01;
                  count_q <= 16'h0000;
               end
               else if (count_q >= ACQ_CYC[15:0] - 16'h0001)
               begin
                  count_q <= 16'h0000;
                  state_q <= ST_CONV;
               end
               else
                  count_q <= count_q + 16'h0001;
            end
            ST_CONV:
            begin
               // Hold input ignored while converting
               if (count_q >= CONV_CYC[15:0] - 16'h0001) // RULE14
               begin
                  count_q <= 16'h0000;
                  state_q <= ST_STORE;
               end
               else
                  count_q <= count_q + 16'h0001;
            end
            ST_STORE:
            begin
               case (resAddrOf(chan_q))
                  `TAG_RES_PRESSURE_FIRST: resPressFirst_q <= convData; // RULE7
                  `TAG_RES_PRESSURE_SECOND: resPressSecond_q <= convData; // RULE8
                  RES_X: resX_q <= convData;
                  RES_Y: resY_q <= convData;
                  default: resX_q <= resX_q;
               endcase
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Plate switches, sense and reference routing, all registered
   always @(posedge clock or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         acqEnable <= 1'b0;
         convActive <= 1'b0;
         convChannel <= 4'h0;
         xPosDrive <= 1'b0;
         xNegDrive <= 1'b0;
         yPosDrive <= 1'b0;
         yNegDrive <= 1'b0;
         senseSel <= SN_XP;
         refRatiometric <= 1'b0;
         refPlate <= RP_NONE;
      end
      else
      begin
         // Gate follows the synchronised hold one cycle later
         acqEnable <= (state_q == ST_ACQ) & ~holdActive; // RULE9 RULE10
         convActive <= (state_q == ST_CONV);
         convChannel <= chan_q;
         xPosDrive <= 1'b0;
         xNegDrive <= 1'b0;
         yPosDrive <= 1'b0;
         yNegDrive <= 1'b0;
         senseSel <= SN_XP;
         refRatiometric <= 1'b0;
         refPlate <= RP_NONE;
         if (state_q == ST_DELAY || state_q == ST_ACQ ||
            (state_q == ST_CONV && !singleEnded)) // RULE4 RULE5
         begin
            case (chan_q)
               `TAG_CH_X:
               begin
                  xPosDrive <= 1'b1; // RULE2
                  xNegDrive <= 1'b1;
                  senseSel <= SN_YP;
                  refRatiometric <= ~singleEnded;
                  refPlate <= singleEnded ? RP_NONE : RP_X;
               end
               `TAG_CH_Y:
               begin
                  yPosDrive <= 1'b1; // RULE3
                  yNegDrive <= 1'b1;
                  senseSel <= SN_XP;
                  refRatiometric <= ~singleEnded;
                  refPlate <= singleEnded ? RP_NONE : RP_Y;
               end
               `TAG_CH_PRESSURE_FIRST:
               begin
                  yPosDrive <= 1'b1; // RULE6
                  xNegDrive <= 1'b1;
                  senseSel <= SN_YN;
                  refRatiometric <= ~singleEnded;
               end
               `TAG_CH_PRESSURE_SECOND:
               begin
                  yPosDrive <= 1'b1; // RULE6
                  xNegDrive <= 1'b1;
                  senseSel <= SN_XP;
                  refRatiometric <= ~singleEnded;
               end
               default: senseSel <= SN_XP;
            endcase
         end
      end
   end
endmodule // tag_touch_ctrl
`default_nettype wire

// ==== tag_touch_ctrl_bench.sv ====
// Testbench for the touch acquisition gating controller
// Assumes the plate model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "tag_consts.vh"
module tag_touch_ctrl_bench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic lcdNoisy = 1'b0;
   logic polHigh = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, acqEnable, convActive, refRatiometric;
   wire logic xPosDrive, xNegDrive, yPosDrive, yNegDrive, holdLine;
   wire logic [3:0] convChannel;
   wire logic [1:0] senseSel, refPlate;
   wire logic [11:0] convData;
   int err_count = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic rdErr;
   always #5 clock = ~clock;
   tag_touch_ctrl #(.ACQ_CYC(8), .CONV_CYC(6), .DELAY_CYC(3)) DUT (.clock,
      .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .acquisition_hold_in(holdLine), .convData, .acqEnable,
      .convActive, .convChannel, .xPosDrive, .xNegDrive, .yPosDrive,
      .yNegDrive, .senseSel, .refRatiometric, .refPlate);
   tag_plate_model plates (.clock, .acqEnable, .drv({xPosDrive, xNegDrive,
      yPosDrive, yNegDrive}), .senseSel, .lcdNoisy, .polHigh, .holdLine,
      .convData);
   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 50 && pready !== 1'b1; n++)
         @(posedge clock);
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(n < 50, 1'b1);
      if (n == 50)
         results();
   endtask
   task automatic waitFor(input bit conv, input logic lvl);
      int n;
      for (n = 0; n < 200 && (conv ? convActive : acqEnable) !== lvl; n++)
         @(posedge clock);
      check(n < 200, 1'b1);
      if (n == 200)
         results();
   endtask
   task automatic testResetRegs();
      apb(1'b0, `TAG_ADDR_CTRL_ONE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `TAG_ADDR_CTRL_TWO, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      check({31'h0, rdErr}, 32'h1);
      check(rd, 32'h0);
   endtask
   task automatic testChannels();
      logic [3:0] chs [4] = '{4'hA, 4'h2, 4'hC, 4'hD};
      logic [11:0] adr [4] = '{12'h068, 12'h048, 12'h070, 12'h074};
      logic [11:0] exp [4] = '{{6'h2B, 4'h6, 2'h2}, {6'h2B, 4'h6, 2'h0},
         {6'h2B, 4'hC, 2'h1}, {6'h2B, 4'h3, 2'h0}};
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, `TAG_ADDR_CTRL_ONE, {20'h0, i == 2, 7'h40, chs[i]});
         waitFor(1'b1, 1'b1);
         waitFor(1'b1, 1'b0);
         repeat (3) @(posedge clock);
         apb(1'b0, adr[i], 32'h0);
         check(rd, {20'h0, exp[i]});
      end
   endtask
   task automatic testHold(input logic hold_polarity);
      logic [7:0] aborts;
      polHigh <= hold_polarity;
      apb(1'b1, `TAG_ADDR_CTRL_TWO, {28'h0, hold_polarity, 3'h0});
      apb(1'b0, `TAG_ADDR_CTRL_TWO, 32'h0);
      check(rd, {28'h0, hold_polarity, 3'h0});
      apb(1'b0, `TAG_ADDR_STATUS, 32'h0);
      aborts = rd[12:5];
      lcdNoisy <= 1'b1;
      repeat (4) @(posedge clock);
      apb(1'b1, `TAG_ADDR_CTRL_ONE, 32'h403);
      repeat (16)
      begin
         @(posedge clock);
         check({acqEnable, convActive}, 2'h0);
      end
      lcdNoisy <= 1'b0;
      waitFor(1'b0, 1'b1);
      lcdNoisy <= 1'b1;
      repeat (6) @(posedge clock);
      check(acqEnable, 1'b0);
      repeat (10)
      begin
         @(posedge clock);
         check({acqEnable, convActive}, 2'h0);
      end
      lcdNoisy <= 1'b0;
      waitFor(1'b1, 1'b1);
      lcdNoisy <= 1'b1;
      waitFor(1'b1, 1'b0);
      lcdNoisy <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1'b0, `TAG_ADDR_STATUS, 32'h0);
      check(rd[12:5], aborts + 8'h01);
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      testResetRegs();
      testChannels();
      testHold(1'b1);
      testHold(1'b0);
      results();
   end
endmodule // tag_touch_ctrl_bench
`default_nettype wire

// ==== tag_touch_ctrl_sva.sv ====
// Port checker for the touch acquisition gating controller
// Assumes binding into tag_touch_ctrl with its timing parameters
`timescale 1ns/1ps
`default_nettype none
module tag_touch_ctrl_sva
#(
   parameter ACQ_CYC = 4,
   parameter CONV_CYC = 6,
   parameter DELAY_CYC = 3
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic acqEnable,
   input wire logic convActive,
   input wire logic [3:0] convChannel,
   input wire logic xPosDrive,
   input wire logic xNegDrive,
   input wire logic yPosDrive,
   input wire logic yNegDrive,
   input wire logic [1:0] senseSel,
   input wire logic refRatiometric,
   input wire logic [1:0] refPlate
);
   logic [7:0] acqRun_q;
   logic [7:0] convRun_q;
   wire logic [3:0] drv = {xPosDrive, xNegDrive, yPosDrive, yNegDrive};
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Length of the current unbroken sampling and conversion runs
   always @(posedge clock or negedge reset_n)
      if (!reset_n)
         acqRun_q <= 8'h00;
      else
         acqRun_q <= acqEnable ? acqRun_q + 8'h01 : 8'h00;
   always @(posedge clock or negedge reset_n)
      if (!reset_n)
         convRun_q <= 8'h00;
      else
         convRun_q <= convActive ? convRun_q + 8'h01 : 8'h00;
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_acq_conv_apart: assert property (!(acqEnable && convActive))
      else $error("sampling during conversion");
   a_acq_full_run: assert property ($rose(convActive) |->
      acqRun_q == ACQ_CYC) else $error("short sampling run");
   a_conv_full_len: assert property ($fell(convActive) |->
      convRun_q == CONV_CYC) else $error("conversion cut short");
   a_ratio_excite: assert property (convActive && refRatiometric
      |-> drv != 4'h0) else $error("ratiometric excitation off");
   a_single_off: assert property (convActive && !refRatiometric
      && convChannel == 4'hC |-> drv == 4'h0) else $error("plate left on");
   a_x_route: assert property (acqEnable && !refRatiometric
      && convChannel == 4'hC |-> drv == 4'hC && senseSel == 2'h1
      && refPlate == 2'h0) else $error("bad X routing");
   a_y_route: assert property (acqEnable && refRatiometric
      && convChannel == 4'hD |-> drv == 4'h3 && senseSel == 2'h0
      && refPlate == 2'h2) else $error("bad Y routing");
   a_press_first: assert property (acqEnable && convChannel == 4'hA
      |-> drv == 4'h6 && senseSel == 2'h2) else $error("bad first press");
   a_press_second: assert property (acqEnable && convChannel == 4'h2
      |-> drv == 4'h6 && senseSel == 2'h0) else $error("bad second press");
endmodule // tag_touch_ctrl_sva
bind tag_touch_ctrl tag_touch_ctrl_sva #(.ACQ_CYC(ACQ_CYC),
   .CONV_CYC(CONV_CYC), .DELAY_CYC(DELAY_CYC)) checker_i (.clock,
   .reset_n, .pready, .pslverr, .acqEnable, .convActive, .convChannel,
   .xPosDrive, .xNegDrive, .yPosDrive, .yNegDrive, .senseSel,
   .refRatiometric, .refPlate);
`default_nettype wire
